// ==== include/lin_uart_cfg.svh ====
// Offsets, field positions, reset values and limits of the LIN/UART register set
`ifndef LIN_UART_CFG_SVH
`define LIN_UART_CFG_SVH

// Byte addresses on the APB side
`define OFF_CONTROL      8'h00
`define OFF_STATUS       8'h04
`define OFF_IRQ_ENABLE   8'h08
`define OFF_ERROR_FLAGS  8'h0C
`define OFF_BIT_TIMING   8'h10
`define OFF_BAUD_DIVIDER 8'h14
`define OFF_RESP_LENGTHS 8'h18
`define OFF_FRAME_IDENT  8'h1C
`define OFF_BUFFER_SEL   8'h20
`define OFF_DATA_PORT    8'h24

// Field positions
`define BIT_LEGACY_SEL   6
`define BIT_UART_MODE    0
`define BIT_ERR_SUMMARY  3
`define BIT_RESYNC_DIS   7
`define BIT_AUTOINC_OFF  3
`define BIT_ABORT        7

// Reset values
`define RST_BYTE         8'h00
`define RST_SPB          6'h20
`define RST_DIVISOR      12'h000
`define RST_IDENT        8'h80

// Limits and length codes
`define SPB_MIN          6'h08
`define SPB_MAX          6'h3F
`define LEN_MAX          4'h8
`define LEN_TWO          4'h2
`define LEN_FOUR         4'h4
`define LEN_EIGHT        4'h8

`endif

// ==== include/lin_uart_pkg.sv ====
// Types shared by the LIN/UART register set
package lin_uart_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [2:0] index_t;
	typedef enum logic [3:0] {
		SEL_CONTROL,
		SEL_STATUS,
		SEL_IRQ_ENABLE,
		SEL_ERROR_FLAGS,
		SEL_BIT_TIMING,
		SEL_BAUD_DIVIDER,
		SEL_RESP_LENGTHS,
		SEL_FRAME_IDENT,
		SEL_BUFFER_SEL,
		SEL_DATA_PORT,
		SEL_NONE
	} reg_sel_t;
endpackage

// ==== src/resp_buffer.sv ====
// Eight-byte response buffer, two ports, registered read data
`timescale 1ns/1ps
module resp_buffer (
	input  wire logic                  clk,
	input  wire lin_uart_pkg::index_t  a_idx,
	input  wire logic                  a_we,
	input  wire lin_uart_pkg::byte_t   a_wdata,
	output      lin_uart_pkg::byte_t   a_rdata,
	input  wire lin_uart_pkg::index_t  b_idx,
	input  wire logic                  b_we,
	input  wire lin_uart_pkg::byte_t   b_wdata,
	output      lin_uart_pkg::byte_t   b_rdata
);
	lin_uart_pkg::byte_t mem_q [0:7];
	lin_uart_pkg::byte_t a_rdata_q;
	lin_uart_pkg::byte_t b_rdata_q;

	// Software port wins a same-address collision
	always_ff @(posedge clk) begin
		if (a_we) begin
			mem_q[a_idx] <= a_wdata;
		end
		if (b_we && !(a_we && a_idx == b_idx)) begin
			mem_q[b_idx] <= b_wdata;
		end
		a_rdata_q <= mem_q[a_idx];
		b_rdata_q <= mem_q[b_idx];
	end

	assign a_rdata = a_rdata_q;
	assign b_rdata = b_rdata_q;
endmodule

// ==== src/lin_uart_register_set.sv ====
// APB register set of the LIN/UART controller
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "lin_uart_cfg.svh"
module lin_uart_register_set (
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output      logic [31:0]  prdata,
	output      logic         pready,
	output      logic         pslverr,
	input  wire logic [6:0]   err_set,
	input  wire logic         abort_cmd,
	input  wire logic         ident_done_set,
	input  wire logic         tx_done_set,
	input  wire logic         rx_done_set,
	input  wire logic         uart_rx_valid,
	input  wire logic [7:0]   uart_rx_byte,
	input  wire logic [2:0]   eng_idx,
	input  wire logic         eng_we,
	input  wire logic [7:0]   eng_wdata,
	output      logic [7:0]   eng_rdata,
	output      logic         irq,
	output      logic         uart_mode,
	output      logic         legacy_protocol_select,
	output      logic         resync_disable,
	output      logic [5:0]   samples_per_bit,
	output      logic [11:0]  baud_divisor,
	output      logic [3:0]   tx_byte_count,
	output      logic [3:0]   rx_byte_count,
	output      logic [3:0]   legacy_length,
	output      logic [5:0]   ident_value,
	output      logic [1:0]   ident_parity,
	output      logic [7:0]   uart_tx_byte,
	output      logic         uart_tx_load
);
	lin_uart_pkg::reg_sel_t sel;
	logic        pready_q, pready_d;
	logic        pslverr_q, pslverr_d;
	logic [31:0] prdata_q, prdata_d;
	logic        acc, wr, rd, data_acc;
	logic        uart_q, uart_d;
	logic        legacy_q, legacy_d;
	logic [2:0]  stat_q, stat_d;
	logic [3:0]  en_q, en_d;
	logic [7:0]  err_q, err_d;
	logic        clr_err;
	logic        resync_dis_q, resync_dis_d;
	logic [5:0]  spb_q, spb_d;
	logic [11:0] div_q, div_d;
	logic [3:0]  tx_cnt_q, tx_cnt_d;
	logic [3:0]  rx_cnt_q, rx_cnt_d;
	logic [7:0]  ident_q, ident_d;
	logic        inc_off_q, inc_off_d;
	lin_uart_pkg::index_t idx_q, idx_d;
	lin_uart_pkg::byte_t  utx_q, utx_d;
	lin_uart_pkg::byte_t  urx_q, urx_d;
	logic        tx_load_q, tx_load_d;
	logic        irq_q, irq_d;
	logic [3:0]  llen_q, llen_d;
	lin_uart_pkg::byte_t  buf_rdata;
	logic [7:0]  wb;
	logic [5:0]  id_new;
	logic [5:0]  idv_q, idv_d;

	// Address decode; only aligned words are mapped
	always_comb begin
		sel = lin_uart_pkg::SEL_NONE;
		case (paddr)
			`OFF_CONTROL:      sel = lin_uart_pkg::SEL_CONTROL;
			`OFF_STATUS:       sel = lin_uart_pkg::SEL_STATUS;
			`OFF_IRQ_ENABLE:   sel = lin_uart_pkg::SEL_IRQ_ENABLE;
			`OFF_ERROR_FLAGS:  sel = lin_uart_pkg::SEL_ERROR_FLAGS;
			`OFF_BIT_TIMING:   sel = lin_uart_pkg::SEL_BIT_TIMING;
			`OFF_BAUD_DIVIDER: sel = lin_uart_pkg::SEL_BAUD_DIVIDER;
			`OFF_RESP_LENGTHS: sel = lin_uart_pkg::SEL_RESP_LENGTHS;
			`OFF_FRAME_IDENT:  sel = lin_uart_pkg::SEL_FRAME_IDENT;
			`OFF_BUFFER_SEL:   sel = lin_uart_pkg::SEL_BUFFER_SEL;
			`OFF_DATA_PORT:    sel = lin_uart_pkg::SEL_DATA_PORT;
			default:           sel = lin_uart_pkg::SEL_NONE;
		endcase
	end

	// Effects happen only at the completing edge of a transfer
	assign acc      = psel && penable && pready_q;
	assign wr       = acc && pwrite;
	assign rd       = acc && !pwrite;
	assign data_acc = acc && sel == lin_uart_pkg::SEL_DATA_PORT;
	assign wb       = pwdata[7:0];
	assign id_new   = pwdata[5:0];
	assign clr_err  = (wr && sel == lin_uart_pkg::SEL_STATUS && wb[`BIT_ERR_SUMMARY])
		|| (rd && sel == lin_uart_pkg::SEL_DATA_PORT && uart_q);

	// Buffer index is the address at setup, so read data is ready for access
	resp_buffer u_buf (
		.clk     (clk),
		.a_idx   (idx_q),
		.a_we    (wr && sel == lin_uart_pkg::SEL_DATA_PORT && !uart_q),
		.a_wdata (wb),
		.a_rdata (buf_rdata),
		.b_idx   (eng_idx),
		.b_we    (eng_we),
		.b_wdata (eng_wdata),
		.b_rdata (eng_rdata)
	);

	// Bus handshake: one wait cycle gives registered read data
	always_comb begin
		pready_d  = psel && penable && !pready_q;
		pslverr_d = pready_d && sel == lin_uart_pkg::SEL_NONE;
		prdata_d  = 32'h0000_0000;
		if (pready_d && !pwrite) begin
			case (sel)
				lin_uart_pkg::SEL_CONTROL: prdata_d[7:0] = {1'b0, legacy_q, 5'b0_0000, uart_q};
				lin_uart_pkg::SEL_STATUS: prdata_d[3:0] = {|err_q, stat_q};
				lin_uart_pkg::SEL_IRQ_ENABLE: prdata_d[3:0] = en_q;
				lin_uart_pkg::SEL_ERROR_FLAGS: prdata_d[7:0] = err_q;
				lin_uart_pkg::SEL_BIT_TIMING: prdata_d[7:0] = {resync_dis_q, 1'b0, spb_q};
				lin_uart_pkg::SEL_BAUD_DIVIDER: prdata_d[11:0] = div_q;
				lin_uart_pkg::SEL_RESP_LENGTHS: prdata_d[7:0] = {tx_cnt_q, rx_cnt_q};
				lin_uart_pkg::SEL_FRAME_IDENT: prdata_d[7:0] = ident_q;
				lin_uart_pkg::SEL_BUFFER_SEL: prdata_d[3:0] = {inc_off_q, idx_q};
				lin_uart_pkg::SEL_DATA_PORT: prdata_d[7:0] = uart_q ? urx_q : buf_rdata;
				default:
					prdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q  <= prdata_d;
		end
	end

	// Flags: a set in the clearing cycle survives the clear
	always_comb begin
		err_d  = clr_err ? 8'h00 : err_q;
		stat_d = (wr && sel == lin_uart_pkg::SEL_STATUS) ? (stat_q & ~wb[2:0]) : stat_q;
		if (wr && sel == lin_uart_pkg::SEL_DATA_PORT && uart_q) begin
			stat_d[1] = 1'b0;
		end
		if (rd && sel == lin_uart_pkg::SEL_DATA_PORT && uart_q) begin
			stat_d[0] = 1'b0;
		end
		err_d[6:0]        = err_d[6:0] | err_set;
		err_d[`BIT_ABORT] = err_d[`BIT_ABORT] | abort_cmd;
		stat_d = stat_d | {ident_done_set, tx_done_set, rx_done_set};
		// Summary flag is derived, so it cannot disagree with the flags
		irq_d = |({|err_d, stat_d} & en_q);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			err_q  <= `RST_BYTE;
			stat_q <= 3'b000;
			irq_q  <= 1'b0;
		end else begin
			err_q  <= err_d;
			stat_q <= stat_d;
			irq_q  <= irq_d;
		end
	end

	// Configuration registers; reserved bits are dropped on write
	always_comb begin
		uart_d       = uart_q;
		legacy_d     = legacy_q;
		en_d         = en_q;
		resync_dis_d = resync_dis_q;
		spb_d        = spb_q;
		div_d        = div_q;
		tx_cnt_d     = tx_cnt_q;
		rx_cnt_d     = rx_cnt_q;
		ident_d      = ident_q;
		inc_off_d    = inc_off_q;
		if (wr) begin
			case (sel)
				lin_uart_pkg::SEL_CONTROL: begin
					uart_d   = wb[`BIT_UART_MODE];
					legacy_d = wb[`BIT_LEGACY_SEL];
				end
				lin_uart_pkg::SEL_IRQ_ENABLE:
					en_d = wb[3:0];
				lin_uart_pkg::SEL_BIT_TIMING: begin
					resync_dis_d = wb[`BIT_RESYNC_DIS];
					// Out-of-range counts would break the sampler
					spb_d = (wb[5:0] < `SPB_MIN) ? `SPB_MIN : wb[5:0];
				end
				lin_uart_pkg::SEL_BAUD_DIVIDER:
					div_d = pwdata[11:0];
				lin_uart_pkg::SEL_RESP_LENGTHS: begin
					tx_cnt_d = (wb[7:4] > `LEN_MAX) ? `LEN_MAX : wb[7:4];
					rx_cnt_d = (wb[3:0] > `LEN_MAX) ? `LEN_MAX : wb[3:0];
				end
				lin_uart_pkg::SEL_FRAME_IDENT: begin
					ident_d[5:0] = id_new;
					ident_d[6]   = id_new[4] ^ id_new[2] ^ id_new[1] ^ id_new[0];
					ident_d[7]   = ~(id_new[1] ^ id_new[3] ^ id_new[4] ^ id_new[5]);
				end
				lin_uart_pkg::SEL_BUFFER_SEL:
					inc_off_d = wb[`BIT_AUTOINC_OFF];
				default: uart_d = uart_q;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			uart_q       <= 1'b0;
			legacy_q     <= 1'b0;
			en_q         <= 4'h0;
			resync_dis_q <= 1'b0;
			spb_q        <= `RST_SPB;
			div_q        <= `RST_DIVISOR;
			tx_cnt_q     <= 4'h0;
			rx_cnt_q     <= 4'h0;
			ident_q      <= `RST_IDENT;
			inc_off_q    <= 1'b0;
		end else begin
			uart_q       <= uart_d;
			legacy_q     <= legacy_d;
			en_q         <= en_d;
			resync_dis_q <= resync_dis_d;
			spb_q        <= spb_d;
			div_q        <= div_d;
			tx_cnt_q     <= tx_cnt_d;
			rx_cnt_q     <= rx_cnt_d;
			ident_q      <= ident_d;
			inc_off_q    <= inc_off_d;
		end
	end

	// Buffer index, UART data path and derived identifier outputs
	always_comb begin
		idx_d     = idx_q;
		utx_d     = utx_q;
		urx_d     = urx_q;
		tx_load_d = 1'b0;
		if (wr && sel == lin_uart_pkg::SEL_BUFFER_SEL) begin
			idx_d = wb[2:0];
		end
		if (data_acc && !uart_q && !inc_off_q) begin
			idx_d = idx_q + 3'd1;
		end
		if (wr && sel == lin_uart_pkg::SEL_DATA_PORT && uart_q) begin
			utx_d     = wb;
			tx_load_d = 1'b1;
		end
		if (uart_rx_valid) begin
			urx_d = uart_rx_byte;
		end
		idv_d = legacy_d ? {2'b00, ident_d[3:0]} : ident_d[5:0];
		case (ident_q[5:4])
			2'b10:   llen_d = `LEN_FOUR;
			2'b11:   llen_d = `LEN_EIGHT;
			default: llen_d = `LEN_TWO;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			idx_q     <= 3'd0;
			utx_q     <= `RST_BYTE;
			urx_q     <= `RST_BYTE;
			tx_load_q <= 1'b0;
			llen_q    <= `LEN_TWO;
			idv_q     <= 6'h00;
		end else begin
			idx_q     <= idx_d;
			utx_q     <= utx_d;
			urx_q     <= urx_d;
			tx_load_q <= tx_load_d;
			llen_q    <= llen_d;
			idv_q     <= idv_d;
		end
	end

	assign prdata                 = prdata_q;
	assign pready                 = pready_q;
	assign pslverr                = pslverr_q;
	assign irq                    = irq_q;
	assign uart_mode              = uart_q;
	assign legacy_protocol_select = legacy_q;
	assign resync_disable         = resync_dis_q;
	assign samples_per_bit        = spb_q;
	assign baud_divisor           = div_q;
	assign tx_byte_count          = tx_cnt_q;
	assign rx_byte_count          = rx_cnt_q;
	assign legacy_length          = llen_q;
	// Legacy layout exposes only the low four identifier bits
	assign ident_value            = idv_q;
	assign ident_parity           = ident_q[7:6];
	assign uart_tx_byte           = utx_q;
	assign uart_tx_load           = tx_load_q;

	// Checks on the register behaviour
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	irq_gate_a: assert property (
		1'b1 |=> irq_q == |({|err_q, stat_q} & $past(en_q)))
		else $error("irq disagrees with flags and enables");
	abort_set_a: assert property (abort_cmd |=> err_q[`BIT_ABORT])
		else $error("abort command did not set abort flag");
	err_clear_a: assert property (
		clr_err && !abort_cmd && err_set == 7'h00 |=> err_q == 8'h00)
		else $error("error flags not cleared with summary");
	err_sticky_a: assert property (
		!clr_err |=> (err_q & $past(err_q)) == $past(err_q))
		else $error("error flag dropped without clear");
	spb_range_a: assert property (spb_q >= `SPB_MIN && spb_q <= `SPB_MAX)
		else $error("samples per bit out of range");
	len_clamp_a: assert property (
		tx_cnt_q <= `LEN_MAX && rx_cnt_q <= `LEN_MAX)
		else $error("byte count above eight");
	ident_parity_a: assert property (
		ident_q[6] == (ident_q[4] ^ ident_q[2] ^ ident_q[1] ^ ident_q[0])
		&& ident_q[7] == ~(ident_q[1] ^ ident_q[3] ^ ident_q[4] ^ ident_q[5]))
		else $error("identifier parity wrong");
	index_step_a: assert property (
		data_acc && !uart_q && !inc_off_q |=> idx_q == $past(idx_q) + 3'd1)
		else $error("index did not advance");
	index_hold_a: assert property (
		data_acc && inc_off_q |=> idx_q == $past(idx_q))
		else $error("index moved with auto-increment off");
	uart_read_clear_a: assert property (
		rd && sel == lin_uart_pkg::SEL_DATA_PORT && uart_q && !rx_done_set
		|=> !stat_q[0])
		else $error("uart data read kept rx-done");
	ready_time_a: assert property (psel && penable && !pready_q |=> pready_q ##1 !pready_q)
		else $error("pready not a single cycle after one wait");

	lin_buf_write_c: cover property (wr && sel == lin_uart_pkg::SEL_DATA_PORT && !uart_q);
	uart_read_c: cover property (rd && sel == lin_uart_pkg::SEL_DATA_PORT && uart_q);
	err_clear_c: cover property (err_q != 8'h00 ##1 clr_err ##1 err_q == 8'h00);
	irq_c: cover property (!irq_q ##1 irq_q);
endmodule

// ==== tb/lin_engine_model.sv ====
// Protocol engine stand-in that drives the event and buffer inputs
`timescale 1ns/1ps
module lin_engine_model (
	input  wire logic        clk,
	output      logic [6:0]  err_set,
	output      logic        abort_cmd,
	output      logic [2:0]  ok_set,
	output      logic        uart_rx_valid,
	output      logic [7:0]  uart_rx_byte,
	output      logic [2:0]  eng_idx,
	output      logic        eng_we,
	output      logic [7:0]  eng_wdata
);
	// Idle values; released data lines show the inverse of the last byte
	initial begin
		err_set = 7'h00;
		abort_cmd = 1'b0;
		ok_set = 3'h0;
		uart_rx_valid = 1'b0;
		uart_rx_byte = 8'h5a;
		eng_idx = 3'h0;
		eng_we = 1'b0;
		eng_wdata = 8'ha5;
	end
	// One-cycle event pulse: error causes, abort, done flags
	task automatic pulse(input logic [6:0] e, input logic ab, input logic [2:0] ok);
		@(posedge clk);
		err_set <= e;
		abort_cmd <= ab;
		ok_set <= ok;
		@(posedge clk);
		err_set <= 7'h00;
		abort_cmd <= 1'b0;
		ok_set <= 3'h0;
		@(negedge clk);
	endtask
	// Received UART byte, valid for one cycle
	task automatic rx_byte(input logic [7:0] b);
		@(posedge clk);
		uart_rx_valid <= 1'b1;
		uart_rx_byte <= b;
		@(posedge clk);
		uart_rx_valid <= 1'b0;
		uart_rx_byte <= ~b;
		@(negedge clk);
	endtask
	// Engine write into the response buffer
	task automatic put(input logic [2:0] i, input logic [7:0] d);
		@(posedge clk);
		eng_idx <= i;
		eng_we <= 1'b1;
		eng_wdata <= d;
		@(posedge clk);
		eng_we <= 1'b0;
		eng_wdata <= ~d;
		@(negedge clk);
	endtask
	// Point the engine port; read data lands one edge later
	task automatic point(input logic [2:0] i);
		@(posedge clk);
		eng_idx <= i;
		@(posedge clk);
		@(negedge clk);
	endtask
endmodule

// ==== tb/lin_uart_register_set_test.sv ====
// Self-checking bench for the LIN/UART register set
`timescale 1ns/1ps
module lin_uart_register_set_test;
	logic        clk, srst, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0]  paddr, eng_wdata, eng_rdata, uart_rx_byte, uart_tx_byte;
	logic [31:0] pwdata, prdata, rd_v, v;
	logic [6:0]  err_set;
	logic [2:0]  ok_set, eng_idx;
	logic        abort_cmd, uart_rx_valid, eng_we, uart_mode, legacy_protocol_select;
	logic        resync_disable, uart_tx_load, se_v;
	logic [5:0]  samples_per_bit, ident_value, id;
	logic [11:0] baud_divisor;
	logic [3:0]  tx_byte_count, rx_byte_count, legacy_length;
	logic [1:0]  ident_parity, par;
	logic [7:0]  bm [8];
	logic [7:0]  ra [7] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
	logic [7:0]  rv [7] = '{8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h80, 8'h00};
	logic [7:0]  bt [5] = '{8'h85, 8'h08, 8'h3f, 8'h20, 8'h07};
	int          err_total, checked, cyc;

	lin_uart_register_set dut (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .err_set, .abort_cmd, .ident_done_set(ok_set[2]),
		.tx_done_set(ok_set[1]), .rx_done_set(ok_set[0]), .uart_rx_valid, .uart_rx_byte,
		.eng_idx, .eng_we, .eng_wdata, .eng_rdata, .irq, .uart_mode, .legacy_protocol_select,
		.resync_disable, .samples_per_bit, .baud_divisor, .tx_byte_count, .rx_byte_count,
		.legacy_length, .ident_value, .ident_parity, .uart_tx_byte, .uart_tx_load);
	lin_engine_model eng (.clk, .err_set, .abort_cmd, .ok_set, .uart_rx_valid,
		.uart_rx_byte, .eng_idx, .eng_we, .eng_wdata);

	// Clock and hang guard
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (err_total == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One APB transfer; held until pready is seen, then released
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Sampled at the rising edge; answer taken at the completing edge
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd_v = prdata;
		se_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge clk);
		chk(n < 20, 1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd_v, e);
	endtask
	task automatic tick();
		@(posedge clk);
		@(negedge clk);
	endtask
	function automatic logic [3:0] cl(input logic [3:0] x);
		return (x > 4'h8) ? 4'h8 : x;
	endfunction

	// Main sequence
	initial begin
		clk = 1'b0;
		srst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		v = $urandom(32'h0000_84b2);
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < 7; i++)
			rd(ra[i], {24'h00_0000, rv[i]});
		chk(legacy_length, 4'h2);
		// Enable and divider read-back, clamps and resync bit
		for (int i = 0; i < 5; i++) begin
			v = $urandom();
			wr(8'h08, v & 32'h0000_000f);
			rd(8'h08, v & 32'h0000_000f);
			wr(8'h14, v & 32'h0000_0fff);
			rd(8'h14, v & 32'h0000_0fff);
			chk(baud_divisor, v[11:0]);
			wr(8'h18, v);
			chk(tx_byte_count, cl(v[7:4]));
			chk(rx_byte_count, cl(v[3:0]));
			wr(8'h10, bt[i]);
			chk(samples_per_bit, (bt[i][5:0] < 6'h08) ? 6'h08 : bt[i][5:0]);
			chk(resync_disable, bt[i][7]);
		end
		// Every identifier in both layouts
		for (int m = 0; m < 2; m++) begin
			wr(8'h00, m << 6);
			chk(legacy_protocol_select, m);
			for (int i = 0; i < 64; i++) begin
				id = i;
				par = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[4] ^ id[2] ^ id[1] ^ id[0]};
				wr(8'h1c, {26'h0, id} | 32'h0000_00c0);
				rd(8'h1c, {24'h0, par, id});
				chk(ident_parity, par);
				chk(legacy_length, id[5] ? (id[4] ? 4'h8 : 4'h4) : 4'h2);
				chk(ident_value, m ? {2'b00, id[3:0]} : id);
			end
		end
		wr(8'h00, 32'h0000_0000);
		// Each error flag: set, summary, mask, read-only, clear
		for (int b = 0; b < 8; b++) begin
			wr(8'h08, 32'h0000_0008);
			eng.pulse((b < 7) ? 7'(1 << b) : 7'h00, b == 7, 3'h0);
			rd(8'h0c, 1 << b);
			rd(8'h04, 32'h0000_0008);
			chk(irq, 1'b1);
			wr(8'h08, 32'h0000_0007);
			tick();
			chk(irq, 1'b0);
			wr(8'h0c, 32'h0000_00ff);
			rd(8'h0c, 1 << b);
			wr(8'h04, 32'h0000_0008);
			rd(8'h0c, 32'h0000_0000);
		end
		// Done flags against their own enables
		for (int b = 0; b < 3; b++) begin
			eng.pulse(7'h00, 1'b0, 3'(1 << b));
			rd(8'h04, 1 << b);
			wr(8'h08, 1 << b);
			tick();
			chk(irq, 1'b1);
			wr(8'h08, ~(1 << b) & 32'h0000_000f);
			tick();
			chk(irq, 1'b0);
			wr(8'h04, 1 << b);
			rd(8'h04, 32'h0000_0000);
		end
		// Buffer fill from index 5 with wrap, then read back
		wr(8'h20, 32'h0000_0005);
		for (int k = 0; k < 8; k++) begin
			v = $urandom();
			bm[(5 + k) % 8] = v[7:0];
			wr(8'h24, v);
		end
		rd(8'h20, 32'h0000_0005);
		for (int k = 0; k < 8; k++)
			rd(8'h24, bm[(5 + k) % 8]);
		wr(8'h20, 32'h0000_000a);
		rd(8'h24, bm[2]);
		rd(8'h24, bm[2]);
		eng.point(3'h3);
		chk(eng_rdata, bm[3]);
		eng.put(3'h6, 8'h3c);
		wr(8'h20, 32'h0000_000e);
		rd(8'h24, 32'h0000_003c);
		// UART data register and its flag side effects
		wr(8'h00, 32'h0000_0001);
		chk(uart_mode, 1'b1);
		eng.pulse(7'h01, 1'b0, 3'h3);
		v = $urandom();
		wr(8'h24, v);
		chk(uart_tx_load, 1'b1);
		chk(uart_tx_byte, v[7:0]);
		rd(8'h04, 32'h0000_0009);
		eng.rx_byte(v[15:8]);
		rd(8'h24, v[15:8]);
		rd(8'h04, 32'h0000_0000);
		rd(8'h0c, 32'h0000_0000);
		// Unmapped and unaligned places
		apb(1'b0, 8'h28, 32'h0000_0000);
		chk(rd_v, 32'h0000_0000);
		chk(se_v, 1'b1);
		apb(1'b1, 8'h05, 32'h0000_00ff);
		chk(se_v, 1'b1);
		finish_test();
	end
endmodule
